// File: rtl/scib_pkg.sv
// shared constants and types for the serial capture link
package scib_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CAP_BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / CAP_BAUD;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned STG_DEPTH = 2800;
  localparam int unsigned STG_W = 12;
  localparam int unsigned CUR_W = 14;
  localparam int unsigned MEM_PAIRS = 2 ** (CUR_W - 1);
  localparam int unsigned TMR_W = 20;
  localparam int unsigned COST_RX_US = 210;
  localparam int unsigned COST_RX_CYC = COST_RX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned COST_IDLE_US = 110;
  localparam int unsigned COST_IDLE_CYC = COST_IDLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HK_MS = 5;
  localparam int unsigned HK_CYC = HK_MS * (CLK_HZ / 1000);
  localparam int unsigned MAX_RATE_BPS = 5600;
  localparam int unsigned BYTE_GAP_CYC =
    (CLK_HZ + MAX_RATE_BPS - 1) / MAX_RATE_BPS;
  localparam int unsigned MAX_SEG_BYTES = 7500;
  localparam int unsigned SYNC_CRS = 4;
  localparam logic [1:0] PROMPT_LEN = 2'h3;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_PCT = 8'h25;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [15:0] MARK_WORD = 16'hffff;
  localparam logic [3:0] NIB_PAD = 4'hf;
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} scib_rx_e;
  typedef enum logic [1:0] {M_RUN, M_PAD, M_MARK} scib_main_e;
  typedef enum logic [2:0] {H_IDLE, H_CAP, H_SYNC, H_CMD, H_GAP} scib_host_e;
endpackage

// File: rtl/scib_if.sv
// link lines between the host end and the device end
`timescale 1ns/1ps
interface scib_if;
  logic capture_gate_line;
  logic clock_handshake_line;
  logic host_to_dev;
  logic dev_to_host;
  modport device (
    input capture_gate_line,
    input clock_handshake_line,
    input host_to_dev,
    output dev_to_host
  );
  modport host (
    output capture_gate_line,
    output clock_handshake_line,
    output host_to_dev,
    input dev_to_host
  );
endinterface

// File: rtl/scib_device.sv
// device end: capture, staging buffer, pair commit and dump
`timescale 1ns/1ps
// How it works
// - start, eight data, stop, no parity
// - line idles low, stop bit low
// - 2800-byte staging buffer before commit
// - gate high frames one transmission
// - sender leaves 5 ms between transmissions
// - fast sender keeps bursts to at most 7500 bytes
// - early new transmission discards old and new
// - 210 us per byte receiving, 110 after
// - sender keeps under 5600 bytes per second
// - commit only complete byte pairs
// - odd byte waits for next transmission
// - power-up pads lone byte with null
// - power-up writes file mark after padding
// - encode printable digits to packed binary
// - command switch turns encoding off
// - host raises both lines to activate
// - carriage returns lock baud, then prompt
// - host positions cursor then dumps
// - dump starts on terminating carriage return
// - dump length bounded by block count
// - dump stops at write cursor or mark
// - no mark right after a mark
// - framing mismatch counts error, enters standby
module scib_device #(
  parameter int unsigned COST_RX_CYC = scib_pkg::COST_RX_CYC,
  parameter int unsigned HK_CYC = scib_pkg::HK_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  scib_if.device lnk,
  input wire logic power_up,
  output logic busy,
  output logic standby,
  output logic overrun,
  output logic encode_on,
  output logic [7:0] err_count,
  output logic [scib_pkg::CUR_W-1:0] write_cursor,
  output logic [scib_pkg::CUR_W-1:0] readout_cursor
);
  import scib_pkg::*;

  // ************************
  // receiver and baud lock
  // ************************
  scib_rx_e rx_st_q, rx_st_d;
  logic [15:0] rx_cnt_q, rx_cnt_d, bit_cyc_q, bit_cyc_d, meas_q, meas_d;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_vld_q, rx_vld_d, ferr_q, ferr_d, lock_q, lock_d;
  logic line, cmd_mode;

  assign line = lnk.host_to_dev;
  assign cmd_mode = lnk.clock_handshake_line & lnk.capture_gate_line;

  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_vld_d = 1'b0;
    ferr_d = 1'b0;
    bit_cyc_d = bit_cyc_q;
    meas_d = meas_q;
    lock_d = lock_q;
    if (!cmd_mode)
    begin
      lock_d = 1'b0;
      meas_d = '0;
      bit_cyc_d = 16'(BIT_CYC);
    end
    else if (!lock_q)
    begin
      rx_st_d = R_IDLE;
      if (line)
        meas_d = meas_q + 16'h1;
      else if (meas_q != '0)
      begin
        bit_cyc_d = meas_q;
        lock_d = 1'b1;
      end
    end
    if (rx_cnt_q != '0)
      rx_cnt_d = rx_cnt_q - 16'h1;
    else
      unique case (rx_st_q)
        R_IDLE:
          if (line && (lock_q || !cmd_mode))
          begin
            rx_cnt_d = bit_cyc_q >> 1;
            rx_st_d = R_START;
          end
        R_START:
        begin
          rx_cnt_d = bit_cyc_q - 16'h1;
          rx_bit_d = '0;
          rx_st_d = line ? R_DATA : R_IDLE;
        end
        R_DATA:
        begin
          rx_sh_d = {~line, rx_sh_q[7:1]};
          rx_cnt_d = bit_cyc_q - 16'h1;
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == 3'(DATA_BITS - 1))
            rx_st_d = R_STOP;
        end
        R_STOP:
        begin
          rx_vld_d = !line;
          ferr_d = line;
          rx_st_d = R_IDLE;
        end
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rx_st_q <= R_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_vld_q <= 1'b0;
      ferr_q <= 1'b0;
      bit_cyc_q <= 16'(BIT_CYC);
      meas_q <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_vld_q <= rx_vld_d;
      ferr_q <= ferr_d;
      bit_cyc_q <= bit_cyc_d;
      meas_q <= meas_d;
      lock_q <= lock_d;
    end
  end

  // ************************
  // staging, commit, commands
  // ************************
  logic [7:0] stg [STG_DEPTH];
  logic [16:0] mem [MEM_PAIRS];
  scib_main_e m_q, m_d;
  logic [STG_W-1:0] wp_q, wp_d, rp_q, rp_d, cnt_q, cnt_d;
  logic [TMR_W-1:0] cost_q, cost_d, hk_q, hk_d;
  logic [CUR_W-1:0] wc_q, wc_d, ps_q, ps_d, rc_q, rc_d, num_q, num_d;
  logic [CUR_W-1:0] blk_q, blk_d;
  logic [7:0] lo_q, lo_d, err_q, err_d, in_b, fd_q[2], fd_d[2];
  logic [3:0] nib_q, nib_d, nv;
  logic [1:0] pr_q, pr_d, fc_q, fc_d;
  logic gate_q, pu_q, have_lo_q, have_lo_d, lm_q, lm_d, dis_q, dis_d;
  logic sb_q, sb_d, ovr_q, ovr_d, enc_q, enc_d, hn_q, hn_d;
  logic pend_q, pend_d, dmp_q, dmp_d, lim_q, lim_d;
  logic push, pop, we, fpush, fpop;
  logic [7:0] push_b, fin;
  logic [16:0] wd, rw;

  // printable digit set packed into nibbles
  function automatic logic [3:0] to_nib(input logic [7:0] c);
    logic [3:0] n;
    n = 4'he;
    if (c >= CH_0 && c <= CH_9)
      n = c[3:0];
    else if (c == 8'h2e)
      n = 4'ha;
    else if (c == 8'h2d)
      n = 4'hb;
    else if (c == 8'h2b)
      n = 4'hc;
    else if (c == 8'h2c)
      n = 4'hd;
    return n;
  endfunction

  assign in_b = rx_sh_q;
  assign rw = mem[rc_q[CUR_W-1:1]];
  assign nv = to_nib(in_b);

  always_comb
  begin
    m_d = m_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cost_d = cost_q;
    hk_d = hk_q;
    wc_d = wc_q;
    ps_d = ps_q;
    rc_d = rc_q;
    num_d = num_q;
    blk_d = blk_q;
    lo_d = lo_q;
    err_d = err_q;
    nib_d = nib_q;
    pr_d = pr_q;
    have_lo_d = have_lo_q;
    lm_d = lm_q;
    dis_d = dis_q;
    sb_d = sb_q;
    ovr_d = ovr_q;
    enc_d = enc_q;
    hn_d = hn_q;
    pend_d = pend_q;
    dmp_d = dmp_q;
    lim_d = lim_q;
    push = 1'b0;
    push_b = rx_sh_q;
    pop = 1'b0;
    we = 1'b0;
    wd = {1'b0, lo_q, stg[rp_q]};
    fpush = 1'b0;
    fin = CH_CR;
    // capture path into staging buffer
    if (rx_vld_q && lnk.capture_gate_line && !cmd_mode && !dis_q && !sb_q)
    begin
      if (!enc_q)
        push = 1'b1;
      else if (hn_q)
      begin
        push = 1'b1;
        push_b = {nib_q, nv};
        hn_d = 1'b0;
      end
      else
      begin
        nib_d = nv;
        hn_d = 1'b1;
      end
    end
    if (gate_q && !lnk.capture_gate_line && !cmd_mode)
    begin
      dis_d = 1'b0;
      hk_d = TMR_W'(HK_CYC);
      if (hn_q)
      begin
        push = 1'b1;
        push_b = {nib_q, NIB_PAD};
        hn_d = 1'b0;
      end
    end
    if (!gate_q && lnk.capture_gate_line && !cmd_mode)
    begin
      sb_d = 1'b0;
      ovr_d = 1'b0;
    end
    if (ferr_q && !cmd_mode && lnk.capture_gate_line)
    begin
      err_d = err_q + 8'h1;
      sb_d = 1'b1;
    end
    if (push && cnt_q == STG_W'(STG_DEPTH))
    begin
      push = 1'b0;
      ovr_d = 1'b1;
    end
    // commit engine
    unique case (m_q)
      M_RUN:
        if (cost_q != '0)
          cost_d = cost_q - TMR_W'(1);
        else if (cnt_q != '0)
        begin
          pop = 1'b1;
          cost_d = lnk.capture_gate_line ? TMR_W'(COST_RX_CYC - 1) :
            TMR_W'(COST_IDLE_CYC - 1);
          if (have_lo_q)
          begin
            we = 1'b1;
            have_lo_d = 1'b0;
          end
          else
          begin
            lo_d = stg[rp_q];
            have_lo_d = 1'b1;
          end
        end
        else if (hk_q != '0)
          hk_d = hk_q - TMR_W'(1);
        else if (power_up && !pu_q)
          m_d = have_lo_q ? M_PAD : M_MARK;
      M_PAD:
      begin
        we = 1'b1;
        wd = {1'b0, lo_q, CH_NUL};
        have_lo_d = 1'b0;
        m_d = M_MARK;
      end
      M_MARK:
      begin
        we = !lm_q;
        wd = {1'b1, MARK_WORD};
        m_d = M_RUN;
      end
      default:
        m_d = M_RUN;
    endcase
    if (we)
    begin
      wc_d = wc_q + CUR_W'(2);
      lm_d = wd[16];
    end
    if (push)
      wp_d = (wp_q == STG_W'(STG_DEPTH - 1)) ? '0 : wp_q + STG_W'(1);
    if (pop)
      rp_d = (rp_q == STG_W'(STG_DEPTH - 1)) ? '0 : rp_q + STG_W'(1);
    cnt_d = cnt_q + STG_W'(push) - STG_W'(pop);
    // new transmission while old bytes remain
    if (!gate_q && lnk.capture_gate_line && !cmd_mode)
    begin
      ps_d = wc_q;
      if (cnt_q != '0)
      begin
        rp_d = wp_q;
        cnt_d = '0;
        wc_d = ps_q;
        have_lo_d = 1'b0;
        dis_d = 1'b1;
        cost_d = '0;
      end
    end
    // command parser
    if (rx_vld_q && cmd_mode)
    begin
      num_d = '0;
      if (in_b >= CH_0 && in_b <= CH_9)
        num_d = CUR_W'(num_q * 10) + CUR_W'(in_b - CH_0);
      else if (in_b == CH_G)
        rc_d = num_q;
      else if (in_b == CH_E)
        enc_d = num_q[0];
      else if (in_b == CH_C || in_b == CH_D || in_b == CH_F)
      begin
        pend_d = 1'b1;
        blk_d = num_q;
        lim_d = num_q != '0;
      end
      else if (in_b == CH_CR)
      begin
        pend_d = 1'b0;
        dmp_d = pend_q;
        if (!pend_q)
          pr_d = PROMPT_LEN;
      end
    end
    // answer source into the two-entry buffer
    if (fc_q != 2'h2)
    begin
      if (pr_q != '0)
      begin
        fpush = 1'b1;
        fin = (pr_q == 2'h3) ? CH_CR : (pr_q == 2'h2) ? CH_LF : CH_PCT;
        pr_d = pr_q - 2'h1;
      end
      else if (dmp_q)
      begin
        if (rc_q == wc_q || rw[16] || (lim_q && blk_q == '0))
        begin
          dmp_d = 1'b0;
          pr_d = PROMPT_LEN;
        end
        else
        begin
          fpush = 1'b1;
          fin = rc_q[0] ? rw[7:0] : rw[15:8];
          rc_d = rc_q + CUR_W'(1);
          blk_d = blk_q - CUR_W'(1);
        end
      end
    end
    if (!cmd_mode)
    begin
      dmp_d = 1'b0;
      pend_d = 1'b0;
      pr_d = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
      stg[wp_q] <= push_b;
    if (we)
      mem[wc_q[CUR_W-1:1]] <= wd;
    if (reset)
    begin
      m_q <= M_RUN;
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      cost_q <= '0;
      hk_q <= '0;
      wc_q <= '0;
      ps_q <= '0;
      rc_q <= '0;
      num_q <= '0;
      blk_q <= '0;
      lo_q <= '0;
      err_q <= '0;
      nib_q <= '0;
      pr_q <= '0;
      gate_q <= 1'b0;
      pu_q <= 1'b0;
      have_lo_q <= 1'b0;
      lm_q <= 1'b0;
      dis_q <= 1'b0;
      sb_q <= 1'b0;
      ovr_q <= 1'b0;
      enc_q <= 1'b1;
      hn_q <= 1'b0;
      pend_q <= 1'b0;
      dmp_q <= 1'b0;
      lim_q <= 1'b0;
    end
    else
    begin
      m_q <= m_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      cost_q <= cost_d;
      hk_q <= hk_d;
      wc_q <= wc_d;
      ps_q <= ps_d;
      rc_q <= rc_d;
      num_q <= num_d;
      blk_q <= blk_d;
      lo_q <= lo_d;
      err_q <= err_d;
      nib_q <= nib_d;
      pr_q <= pr_d;
      gate_q <= lnk.capture_gate_line;
      pu_q <= power_up;
      have_lo_q <= have_lo_d;
      lm_q <= lm_d;
      dis_q <= dis_d;
      sb_q <= sb_d;
      ovr_q <= ovr_d;
      enc_q <= enc_d;
      hn_q <= hn_d;
      pend_q <= pend_d;
      dmp_q <= dmp_d;
      lim_q <= lim_d;
    end
  end

  // ************************
  // two-entry buffer and transmitter
  // ************************
  logic [9:0] tsh_q, tsh_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic [3:0] tbit_q, tbit_d;

  assign fpop = fc_q != '0 && tbit_q == '0;

  always_comb
  begin
    fd_d = fd_q;
    fc_d = fc_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    if (fpop)
    begin
      tsh_d = {1'b1, fd_q[0], 1'b0};
      tcnt_d = bit_cyc_q - 16'h1;
      tbit_d = 4'(FRAME_BITS);
      fd_d[0] = fd_q[1];
    end
    else if (tbit_q != '0)
    begin
      if (tcnt_q != '0)
        tcnt_d = tcnt_q - 16'h1;
      else
      begin
        tsh_d = {1'b1, tsh_q[9:1]};
        tcnt_d = bit_cyc_q - 16'h1;
        tbit_d = tbit_q - 4'h1;
      end
    end
    if (fpush)
      fd_d[(fc_q == 2'h0 || (fc_q == 2'h1 && fpop)) ? 0 : 1] = fin;
    fc_d = fc_q + 2'(fpush) - 2'(fpop);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      fd_q[0] <= '0;
      fd_q[1] <= '0;
      fc_q <= '0;
      tsh_q <= '1;
      tcnt_q <= '0;
      tbit_q <= '0;
    end
    else
    begin
      fd_q <= fd_d;
      fc_q <= fc_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
    end
  end

  assign lnk.dev_to_host = ~tsh_q[0];
  assign busy = cnt_q != '0 || cost_q != '0 || hk_q != '0;
  assign standby = sb_q;
  assign overrun = ovr_q;
  assign encode_on = enc_q;
  assign err_count = err_q;
  assign write_cursor = wc_q;
  assign readout_cursor = rc_q;
endmodule

// File: rtl/scib_host.sv
// host end: activation, paced sending and answer reception
`timescale 1ns/1ps
module scib_host #(
  parameter int unsigned GAP_CYC = scib_pkg::HK_CYC,
  parameter int unsigned MAX_SEG = scib_pkg::MAX_SEG_BYTES
) (
  input wire logic core_clk,
  input wire logic reset,
  scib_if.host lnk,
  input wire logic capture_req,
  input wire logic retrieve_req,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic prompt_seen
);
  import scib_pkg::*;

  // ************************
  // sequencer and transmitter
  // ************************
  scib_host_e st_q, st_d;
  logic [TMR_W-1:0] tm_q, tm_d;
  logic [12:0] seg_q, seg_d;
  logic [2:0] sc_q, sc_d;
  logic [9:0] tsh_q, tsh_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic [3:0] tbit_q, tbit_d;
  logic gate_q, gate_d, hs_q, hs_d, send;
  logic [7:0] sb;

  always_comb
  begin
    st_d = st_q;
    tm_d = (tm_q != '0) ? tm_q - TMR_W'(1) : tm_q;
    seg_d = seg_q;
    sc_d = sc_q;
    gate_d = gate_q;
    hs_d = hs_q;
    tx_ready = 1'b0;
    send = 1'b0;
    sb = tx_data;
    unique case (st_q)
      H_IDLE:
        if (retrieve_req)
        begin
          gate_d = 1'b1;
          hs_d = 1'b1;
          sc_d = 3'(SYNC_CRS);
          st_d = H_SYNC;
        end
        else if (capture_req)
        begin
          gate_d = 1'b1;
          seg_d = '0;
          st_d = H_CAP;
        end
      H_CAP:
      begin
        tx_ready = tbit_q == '0 && tm_q == '0 && capture_req &&
          seg_q != 13'(MAX_SEG);
        send = tx_ready && tx_valid;
        if (send)
        begin
          tm_d = TMR_W'(BYTE_GAP_CYC - 1);
          seg_d = seg_q + 13'h1;
        end
        else if (tbit_q == '0 && (!capture_req || seg_q == 13'(MAX_SEG)))
        begin
          gate_d = 1'b0;
          tm_d = TMR_W'(GAP_CYC);
          st_d = H_GAP;
        end
      end
      H_SYNC:
        if (sc_q == '0)
          st_d = H_CMD;
        else if (tbit_q == '0 && tm_q == '0)
        begin
          send = 1'b1;
          sb = CH_CR;
          sc_d = sc_q - 3'h1;
          tm_d = TMR_W'(2 * BIT_CYC * FRAME_BITS);
        end
      H_CMD:
      begin
        tx_ready = tbit_q == '0;
        send = tx_ready && tx_valid;
        if (!retrieve_req && tbit_q == '0)
        begin
          gate_d = 1'b0;
          hs_d = 1'b0;
          tm_d = TMR_W'(GAP_CYC);
          st_d = H_GAP;
        end
      end
      H_GAP:
        if (tm_q == '0)
          st_d = H_IDLE;
      default:
        st_d = H_IDLE;
    endcase
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    if (send)
    begin
      tsh_d = {1'b1, sb, 1'b0};
      tcnt_d = 16'(BIT_CYC - 1);
      tbit_d = 4'(FRAME_BITS);
    end
    else if (tbit_q != '0)
    begin
      if (tcnt_q != '0)
        tcnt_d = tcnt_q - 16'h1;
      else
      begin
        tsh_d = {1'b1, tsh_q[9:1]};
        tcnt_d = 16'(BIT_CYC - 1);
        tbit_d = tbit_q - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q <= H_IDLE;
      tm_q <= '0;
      seg_q <= '0;
      sc_q <= '0;
      gate_q <= 1'b0;
      hs_q <= 1'b0;
      tsh_q <= '1;
      tcnt_q <= '0;
      tbit_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      tm_q <= tm_d;
      seg_q <= seg_d;
      sc_q <= sc_d;
      gate_q <= gate_d;
      hs_q <= hs_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
    end
  end

  assign lnk.capture_gate_line = gate_q;
  assign lnk.clock_handshake_line = hs_q;
  assign lnk.host_to_dev = ~tsh_q[0];

  // ************************
  // answer receiver
  // ************************
  scib_rx_e rx_q, rx_d;
  logic [15:0] rc_q, rc_d;
  logic [2:0] rb_q, rb_d;
  logic [7:0] rs_q, rs_d, rd_q, rd_d;
  logic rv_q, rv_d, ps_q, ps_d;
  logic line;

  assign line = lnk.dev_to_host;

  always_comb
  begin
    rx_d = rx_q;
    rc_d = rc_q;
    rb_d = rb_q;
    rs_d = rs_q;
    rd_d = rd_q;
    rv_d = 1'b0;
    ps_d = ps_q;
    if (st_q == H_SYNC)
      ps_d = 1'b0;
    if (rc_q != '0)
      rc_d = rc_q - 16'h1;
    else
      unique case (rx_q)
        R_IDLE:
          if (line)
          begin
            rc_d = 16'(BIT_CYC / 2);
            rx_d = R_START;
          end
        R_START:
        begin
          rc_d = 16'(BIT_CYC - 1);
          rb_d = '0;
          rx_d = line ? R_DATA : R_IDLE;
        end
        R_DATA:
        begin
          rs_d = {~line, rs_q[7:1]};
          rc_d = 16'(BIT_CYC - 1);
          rb_d = rb_q + 3'h1;
          if (rb_q == 3'(DATA_BITS - 1))
            rx_d = R_STOP;
        end
        R_STOP:
        begin
          rv_d = !line;
          rd_d = rs_q;
          if (!line && rs_q == CH_PCT)
            ps_d = 1'b1;
          rx_d = R_IDLE;
        end
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rx_q <= R_IDLE;
      rc_q <= '0;
      rb_q <= '0;
      rs_q <= '0;
      rd_q <= '0;
      rv_q <= 1'b0;
      ps_q <= 1'b0;
    end
    else
    begin
      rx_q <= rx_d;
      rc_q <= rc_d;
      rb_q <= rb_d;
      rs_q <= rs_d;
      rd_q <= rd_d;
      rv_q <= rv_d;
      ps_q <= ps_d;
    end
  end

  assign rx_data = rd_q;
  assign rx_valid = rv_q;
  assign prompt_seen = ps_q;
endmodule

// File: test/scib_checker.sv
// wire-level checks for the serial capture link
`timescale 1ns/1ps
module scib_checker #(
  parameter int unsigned GAP_CYC = scib_pkg::HK_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic capture_gate_line,
  input wire logic clock_handshake_line,
  input wire logic host_to_dev,
  input wire logic dev_to_host
);
  import scib_pkg::*;
  localparam int unsigned HALF = BIT_CYC / 2;
  localparam int unsigned STOP = 9 * BIT_CYC + HALF;
  logic in_frame_q, in_frame_d, seen_hi_q, seen_hi_d;
  logic [15:0] fcnt_q, fcnt_d;
  logic [TMR_W-1:0] gcnt_q, gcnt_d;
  // ****************************************
  // frame position and gate low time
  // ****************************************
  always_comb
  begin
    in_frame_d = in_frame_q;
    fcnt_d = fcnt_q + 16'h1;
    if (!in_frame_q && host_to_dev)
    begin
      in_frame_d = 1'b1;
      fcnt_d = 16'h1;
    end
    else if (in_frame_q && fcnt_q == 16'(STOP))
    begin
      in_frame_d = 1'b0;
    end
    gcnt_d = gcnt_q + TMR_W'(gcnt_q != '1);
    if (capture_gate_line)
    begin
      gcnt_d = '0;
    end
    seen_hi_d = seen_hi_q | capture_gate_line;
  end
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      in_frame_q <= 1'b0;
      seen_hi_q <= 1'b0;
      fcnt_q <= 16'h0;
      gcnt_q <= '0;
    end
    else
    begin
      in_frame_q <= in_frame_d;
      seen_hi_q <= seen_hi_d;
      fcnt_q <= fcnt_d;
      gcnt_q <= gcnt_d;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_start_mid;
    in_frame_q && fcnt_q == 16'(HALF);
  endsequence
  sequence s_stop_mid;
    in_frame_q && fcnt_q == 16'(STOP);
  endsequence
  AST_START_HIGH: assert property (s_start_mid |-> host_to_dev)
    else $error("start bit not high");
  AST_STOP_LOW: assert property (s_stop_mid |-> !host_to_dev)
    else $error("stop bit not low");
  AST_BIT_EDGE: assert property (in_frame_q &&
    $changed(host_to_dev) |-> fcnt_q % 16'(BIT_CYC) == 16'h0)
    else $error("line moved inside a bit");
  AST_GATE_WHOLE: assert property (in_frame_q |->
    capture_gate_line)
    else $error("gate fell inside a frame");
  AST_NO_TX_OUTSIDE: assert property (!capture_gate_line |->
    !host_to_dev)
    else $error("serial line active without gate");
  AST_GAP: assert property ($rose(capture_gate_line) &&
    seen_hi_q |-> gcnt_q >= TMR_W'(GAP_CYC))
    else $error("gate gap too short");
  AST_DEV_QUIET: assert property (!clock_handshake_line &&
    !$past(clock_handshake_line) |-> !dev_to_host)
    else $error("device sent outside command mode");
  AST_RESET_IDLE: assert property ($fell(reset) |-> !host_to_dev &&
    !dev_to_host && !capture_gate_line)
    else $error("lines not idle low after reset");
endmodule

// File: test/tb_top.sv
// self-checking bench for the serial capture link
`timescale 1ns/1ps
module tb_top;
  import scib_pkg::*;
  localparam int unsigned GAP = 200;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic power_up = 1'b0;
  logic capture_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_ready, rx_valid, prompt_seen, busy, standby, overrun, encode_on;
  logic [7:0] rx_data, err_count;
  logic [CUR_W-1:0] write_cursor, readout_cursor;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  scib_if scib_if_inst ();
  scib_device #(.COST_RX_CYC(20), .HK_CYC(50)) scib_device_inst (
    .core_clk(core_clk), .reset(reset), .lnk(scib_if_inst),
    .power_up(power_up), .busy(busy), .standby(standby),
    .overrun(overrun), .encode_on(encode_on), .err_count(err_count),
    .write_cursor(write_cursor), .readout_cursor(readout_cursor));
  scib_host #(.GAP_CYC(GAP), .MAX_SEG(16)) scib_host_inst (
    .core_clk(core_clk), .reset(reset), .lnk(scib_if_inst),
    .capture_req(capture_req), .retrieve_req(1'b0), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .prompt_seen(prompt_seen));
  scib_checker #(.GAP_CYC(GAP)) scib_checker_inst (
    .core_clk(core_clk), .reset(reset),
    .capture_gate_line(scib_if_inst.capture_gate_line),
    .clock_handshake_line(scib_if_inst.clock_handshake_line),
    .host_to_dev(scib_if_inst.host_to_dev),
    .dev_to_host(scib_if_inst.dev_to_host));
  always #25 core_clk = ~core_clk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic close_out;
    if (fail_count == 0 && compares > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) tick(1);
    tick(1);
    tx_valid = 1'b0;
    tick(1);
  endtask
  task automatic capture(input logic [7:0] a, input logic [7:0] b, int n);
    capture_req = 1'b1;
    send(a);
    if (n == 2) send(b);
    tick(FRAME_BITS * BIT_CYC + BIT_CYC);
    capture_req = 1'b0;
    while (scib_if_inst.capture_gate_line !== 1'b0) tick(1);
    tick(10);
    while (busy !== 1'b0) tick(1);
    tick(GAP);
  endtask
  task automatic power;
    power_up = 1'b1;
    tick(4);
    power_up = 1'b0;
    tick(50);
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      fail_count++;
      close_out();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    tick(4);
    reset = 1'b0;
    tick(1);
    chk(encode_on, 1);
    chk(write_cursor, 0);
    chk(readout_cursor, 0);
    chk(err_count, 0);
    capture(8'h31, 8'h32, 2);
    chk(write_cursor, 0);
    capture(8'h33, 8'h00, 1);
    chk(write_cursor, 2);
    chk(scib_device_inst.mem[0], 17'h0123f);
    power();
    chk(write_cursor, 4);
    chk(scib_device_inst.mem[1], 17'h1ffff);
    power();
    chk(write_cursor, 4);
    capture(8'h34, 8'h00, 1);
    chk(write_cursor, 4);
    power();
    chk(write_cursor, 8);
    chk(scib_device_inst.mem[2], 17'h04f00);
    chk(scib_device_inst.mem[3], 17'h1ffff);
    chk(overrun, 0);
    chk(standby, 0);
    chk(prompt_seen, 0);
    close_out();
  end
endmodule
